// *** hw/flash_cmd_ctl.sv ***
// Flash controller command unlock, erase arming, page choice and sector protect.
//
// Notes on behaviour
// - Unlock needs 73H then directly 8CH.
// - Unlocked controller arms mass or page erase.
// - Page erase touches only the chosen page.
// - Mass erase only from the debugger path.
// - Bad value or order relocks immediately.
// - Command address is write-only; reads give status.
// - 95H erases page only as third command.
// - 63H erases mass only as third command.
// - 5EH exposes sector protect at page address.
// - Status readable always, shows present state.
// - Status bits 7 and 6 read zero.
// - Locked 0, unlocked 3, protect selected 4.
// - First unlock byte 1, second byte 2.
// - Busy codes: program 001, page 010, mass 100.
// - Page address writes hit page choice normally.
// - Page field equals address bits 15:9.
// - Page field names erase and program page.
// - Bit 7 maps the information area.
// - Software keeps unused page bits zero.
// - Finished page erase relocks by itself.
// - User writes only set protect bits.
// - Other commands deselect sector protect.
// - Programming only after unlock and erase enable; the code opens programming on unlock alone.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module flash_cmd_ctl #(
	parameter int PAGE_W = 7
) (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	flash_reg_if.ctl               bus,
	input  wire logic              erase_done,
	input  wire logic              prog_busy,
	output logic                   page_erase_start,
	output logic                   mass_erase_start,
	output logic [PAGE_W-1:0]      erase_page,
	output logic [15:0]            page_base_addr,
	output logic                   info_area_map_enable,
	output logic                   prog_page_open,
	output logic                   prog_all_open,
	output logic [7:0]             sector_protect,
	output logic [7:0]             command_byte
);
	import flash_cmd_pkg::*;

	// The page field must fill the bits under the information enable bit.
	if (PAGE_W != PAGE_BIT_INFO) begin : g_bad_width
		$error("PAGE_W must be 7");
	end

	// Every piece of state lives in this one record.
	typedef struct packed {
		ctl_state_e          st;
		logic                dbg_unlock;
		logic [7:0]          page;
		logic [7:0]          prot;
		logic [7:0]          cmd;
		logic [7:0]          rdata;
		logic                rvalid;
		logic                pe_start;
		logic                me_start;
		logic [PAGE_W-1:0]   erase_page;
		logic                page_open;
		logic                all_open;
	} ctl_s;

	ctl_s q;
	ctl_s d;
	logic wr_cmd;
	logic wr_page;
	logic busy;

	// Address decode of the two register-file locations.
	assign wr_cmd  = bus.wr && (bus.addr == ADDR_COMMAND);
	assign wr_page = bus.wr && (bus.addr == ADDR_PAGE);
	assign busy    = (q.st == ST_PAGE_ERASE) || (q.st == ST_MASS_ERASE)
		|| (q.st == ST_PROGRAM);

	// Status encoding of the present state.
	function automatic logic [7:0] status_of(input ctl_state_e s);
		logic [5:0] f;
		f = STAT_LOCKED;
		unique case (s)
			ST_LOCKED:     f = STAT_LOCKED;
			ST_FIRST:      f = STAT_FIRST;
			ST_SECOND:     f = STAT_SECOND;
			ST_UNLOCKED:   f = STAT_UNLOCKED;
			ST_PROT_SEL:   f = STAT_PROT_SEL;
			ST_PROGRAM:    f = STAT_PROGRAM;
			ST_PAGE_ERASE: f = STAT_PAGE_ERASE;
			ST_MASS_ERASE: f = STAT_MASS_ERASE;
		endcase
		return {2'b00, f};
	endfunction

	// Next-state logic: reads, command sequencing and the shared page address.
	always_comb begin
		d          = q;
		d.pe_start = 1'b0;
		d.me_start = 1'b0;
		d.rvalid   = 1'b0;

		// Reads answer one cycle later, whatever the controller is doing.
		if (bus.rd) begin
			d.rvalid = 1'b1;
			d.rdata  = 8'h00;
			if (bus.addr == ADDR_COMMAND) begin
				d.rdata = status_of(q.st);
			end else if (bus.addr == ADDR_PAGE) begin
				d.rdata = (q.st == ST_PROT_SEL) ? q.prot : q.page;
			end
		end

		// Operations in flight advance on the array's own signals.
		unique case (q.st)
			ST_PAGE_ERASE, ST_MASS_ERASE: begin
				if (erase_done) begin
					d.st = ST_LOCKED;
				end
			end
			ST_UNLOCKED: begin
				if (prog_busy) begin
					d.st = ST_PROGRAM;
				end
			end
			ST_PROGRAM: begin
				if (!prog_busy) begin
					d.st = ST_UNLOCKED;
				end
			end
			default: begin
			end
		endcase

		// Command writes are ignored while the CPU would be idled by an operation.
		if (wr_cmd && !busy) begin
			d.cmd = bus.wdata;
			d.st  = ST_LOCKED;
			unique case (q.st)
				ST_LOCKED: begin
					if (bus.wdata == CMD_UNLOCK_1) begin
						d.st = ST_FIRST;
					end else if (bus.wdata == CMD_PROT_SEL) begin
						d.st = ST_PROT_SEL;
					end
				end
				ST_FIRST: begin
					if (bus.wdata == CMD_UNLOCK_2) begin
						d.dbg_unlock = bus.dbg;
						// The debugger needs no page write to finish unlocking.
						d.st = bus.dbg ? ST_UNLOCKED : ST_SECOND;
					end
				end
				ST_UNLOCKED: begin
					if (bus.wdata == CMD_PAGE_ERASE) begin
						d.st         = ST_PAGE_ERASE;
						d.pe_start   = 1'b1;
						d.erase_page = q.page[PAGE_W-1:0];
					end else if (bus.wdata == CMD_MASS_ERASE && bus.dbg) begin
						d.st       = ST_MASS_ERASE;
						d.me_start = 1'b1;
					end
				end
				ST_PROT_SEL: begin
					// Repeating the select byte keeps the protect register reachable.
					if (bus.wdata == CMD_PROT_SEL) begin
						d.st = ST_PROT_SEL;
					end
				end
				default: begin
				end
			endcase
		end

		// The shared page address.
		if (wr_page) begin
			if (q.st == ST_PROT_SEL) begin
				d.prot = bus.dbg ? bus.wdata : (q.prot | bus.wdata);
			end else begin
				d.page = bus.wdata;
				// A page write after the second unlock byte completes a CPU unlock.
				if (q.st == ST_SECOND) begin
					d.st = ST_UNLOCKED;
				end
			end
		end

		d.page_open = ((d.st == ST_UNLOCKED) || (d.st == ST_PROGRAM)) && !d.dbg_unlock;
		d.all_open  = ((d.st == ST_UNLOCKED) || (d.st == ST_PROGRAM)) && d.dbg_unlock;
	end

	// State register; protect bits also clear on reset, losing earlier protection.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			q.st         <= ST_LOCKED;
			q.dbg_unlock <= 1'b0;
			q.page       <= PAGE_RESET;
			q.prot       <= PROT_RESET;
			q.cmd        <= COMMAND_RESET;
			q.rdata      <= 8'h00;
			q.rvalid     <= 1'b0;
			q.pe_start   <= 1'b0;
			q.me_start   <= 1'b0;
			q.erase_page <= '0;
			q.page_open  <= 1'b0;
			q.all_open   <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// Outputs all come straight from the state record.
	assign bus.rdata            = q.rdata;
	assign bus.rvalid           = q.rvalid;
	assign page_erase_start     = q.pe_start;
	assign mass_erase_start     = q.me_start;
	assign erase_page           = q.erase_page;
	assign page_base_addr       = {q.page[PAGE_W-1:0], {PAGE_ADDR_LSB{1'b0}}};
	assign info_area_map_enable = q.page[PAGE_BIT_INFO];
	assign prog_page_open       = q.page_open;
	assign prog_all_open        = q.all_open;
	assign sector_protect       = q.prot;
	assign command_byte         = q.cmd;

endmodule // flash_cmd_ctl

// *** hw/flash_cmd_master.sv ***
// Register master that turns Avalon-MM orders into flash controller register accesses.
`timescale 1ns/1ps
module flash_cmd_master (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic [3:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	flash_reg_if.cpu               bus
);
	import flash_cmd_pkg::*;

	// Every piece of state lives in this one record.
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
		logic        dbg;
		logic        waiting;
		logic [7:0]  rdat;
		logic        wreq;
		logic [31:0] rdout;
	} host_s;

	host_s q;
	host_s d;
	logic  req_wr;
	logic  stall;

	assign req_wr = avs_write && (avs_address == HOST_REQ);
	// A new order waits while a read is still outstanding on the link.
	assign stall  = req_wr && (q.waiting || q.rd);

	// Next-state logic: the waitrequest flop drops for exactly one cycle per access.
	always_comb begin
		d      = q;
		d.wr   = 1'b0;
		d.rd   = 1'b0;
		d.wreq = 1'b1;
		if (bus.rvalid) begin
			d.waiting = 1'b0;
			d.rdat    = bus.rdata;
		end
		// An access held from the previous acknowledge is not served twice.
		if ((avs_read || avs_write) && q.wreq && !stall) begin
			d.wreq = 1'b0;
			if (req_wr) begin
				d.addr    = avs_writedata[REQ_ADDR_LSB +: 12];
				d.wdata   = avs_writedata[7:0];
				d.dbg     = avs_writedata[REQ_BIT_DEBUG];
				d.rd      = avs_writedata[REQ_BIT_READ];
				d.wr      = !avs_writedata[REQ_BIT_READ];
				d.waiting = avs_writedata[REQ_BIT_READ];
			end
			d.rdout = 32'h0000_0000;
			if (avs_read && avs_address == HOST_STAT) begin
				d.rdout = {16'h0000, q.rdat, 7'h00, q.waiting || q.rd};
			end
		end
	end

	// State register.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			q.addr    <= 12'h000;
			q.wdata   <= 8'h00;
			q.wr      <= 1'b0;
			q.rd      <= 1'b0;
			q.dbg     <= 1'b0;
			q.waiting <= 1'b0;
			q.rdat    <= 8'h00;
			q.wreq    <= 1'b1;
			q.rdout   <= 32'h0000_0000;
		end else begin
			q <= d;
		end
	end

	assign avs_readdata    = q.rdout;
	assign avs_waitrequest = q.wreq;
	assign bus.addr        = q.addr;
	assign bus.wdata       = q.wdata;
	assign bus.wr          = q.wr;
	assign bus.rd          = q.rd;
	assign bus.dbg         = q.dbg;

endmodule // flash_cmd_master

// *** hw/flash_cmd_pkg.sv ***
// Shared constants and types for the flash command front end and its register master.
package flash_cmd_pkg;

	// Register-file addresses of the controller.
	localparam logic [11:0] ADDR_COMMAND = 12'h0ff8;
	localparam logic [11:0] ADDR_PAGE    = 12'h0ff9;

	// Command byte values.
	localparam logic [7:0] CMD_UNLOCK_1   = 8'h73;
	localparam logic [7:0] CMD_UNLOCK_2   = 8'h8c;
	localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
	localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
	localparam logic [7:0] CMD_PROT_SEL   = 8'h5e;

	// Status field codes; bits 7:6 of the status byte always read zero.
	localparam logic [5:0] STAT_LOCKED     = 6'h00;
	localparam logic [5:0] STAT_FIRST      = 6'h01;
	localparam logic [5:0] STAT_SECOND     = 6'h02;
	localparam logic [5:0] STAT_UNLOCKED   = 6'h03;
	localparam logic [5:0] STAT_PROT_SEL   = 6'h04;
	localparam logic [5:0] STAT_PROGRAM    = 6'h08;
	localparam logic [5:0] STAT_PAGE_ERASE = 6'h10;
	localparam logic [5:0] STAT_MASS_ERASE = 6'h20;

	// Page choice layout and reset values.
	localparam int          PAGE_BIT_INFO  = 7;
	localparam int          PAGE_ADDR_LSB  = 9;
	localparam logic [7:0]  PAGE_RESET     = 8'h00;
	localparam logic [7:0]  PROT_RESET     = 8'h00;
	localparam logic [7:0]  COMMAND_RESET  = 8'h00;

	// Host-side Avalon register map (byte addresses).
	localparam logic [3:0]  HOST_REQ       = 4'h0;
	localparam logic [3:0]  HOST_STAT      = 4'h4;
	localparam int          REQ_ADDR_LSB   = 8;
	localparam int          REQ_BIT_READ   = 20;
	localparam int          REQ_BIT_DEBUG  = 21;
	localparam int          STAT_DATA_LSB  = 8;

	// Controller states; Gray steps along the CPU unlock path and into page erase.
	typedef enum logic [2:0] {
		ST_LOCKED     = 3'b000,
		ST_FIRST      = 3'b001,
		ST_SECOND     = 3'b011,
		ST_UNLOCKED   = 3'b010,
		ST_PAGE_ERASE = 3'b110,
		ST_MASS_ERASE = 3'b111,
		ST_PROGRAM    = 3'b101,
		ST_PROT_SEL   = 3'b100
	} ctl_state_e;

endpackage

// *** hw/flash_reg_if.sv ***
// Register-file link between the command master and the flash controller.
`timescale 1ns/1ps
interface flash_reg_if;
	logic [11:0] addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic        dbg;
	logic [7:0]  rdata;
	logic        rvalid;

	modport ctl (
		input  addr,
		input  wdata,
		input  wr,
		input  rd,
		input  dbg,
		output rdata,
		output rvalid
	);

	modport cpu (
		output addr,
		output wdata,
		output wr,
		output rd,
		output dbg,
		input  rdata,
		input  rvalid
	);
endinterface

// *** sim/flash_link_sva.sv ***
// Assertions on the register link between the command master and the controller.
`timescale 1ns/1ps
module flash_link_sva
	import flash_cmd_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic [11:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic        dbg,
	input wire logic [7:0]  rdata,
	input wire logic        rvalid
);
	import flash_cmd_pkg::*;
	logic [7:0] cmd0_q;
	logic [7:0] cmd1_q;
	logic [7:0] page_q;
	logic       cdbg_q;

	// Last two command bytes and the page byte, as seen on the link.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cmd0_q <= 8'h00;
			cmd1_q <= 8'h00;
			page_q <= PAGE_RESET;
			cdbg_q <= 1'b0;
		end else if (wr && addr == ADDR_COMMAND) begin
			cmd0_q <= cmd1_q;
			cmd1_q <= wdata;
			cdbg_q <= dbg;
		end else if (wr && addr == ADDR_PAGE && cmd1_q != CMD_PROT_SEL) begin
			page_q <= wdata;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_read_answer: assert property (rd |=> rvalid)
		else $error("link read not answered in the next cycle");
	a_no_stray_answer: assert property (!rd |=> !rvalid)
		else $error("read answer without a read");
	a_status_reserved: assert property (
		rvalid && $past(addr) == ADDR_COMMAND |-> rdata[7:6] == 2'b00)
		else $error("status reserved bits not zero");
	a_bad_cmd_locks: assert property (
		rvalid && $past(addr) == ADDR_COMMAND && cmd1_q == 8'h00 |-> rdata == 8'h00)
		else $error("invalid command did not relock");
	a_first_byte_code: assert property (
		rvalid && $past(addr) == ADDR_COMMAND && cmd0_q == 8'h00 && cmd1_q == CMD_UNLOCK_1
		|-> rdata == {2'b00, STAT_FIRST})
		else $error("first unlock status wrong");
	a_protect_sel_code: assert property (
		rvalid && $past(addr) == ADDR_COMMAND && cmd0_q == 8'h00 && cmd1_q == CMD_PROT_SEL
		|-> rdata == {2'b00, STAT_PROT_SEL})
		else $error("protect select status wrong");
	a_cpu_mass_refused: assert property (
		rvalid && $past(addr) == ADDR_COMMAND && cmd1_q == CMD_MASS_ERASE && !cdbg_q
		|-> rdata == 8'h00)
		else $error("mass erase from the cpu accepted");
	a_page_readback: assert property (
		rvalid && $past(addr) == ADDR_PAGE && cmd1_q != CMD_PROT_SEL |-> rdata == page_q)
		else $error("page choice read back wrong");
endmodule // flash_link_sva

// *** sim/tb_top.sv ***
// Self-checking bench for the flash command master and controller joined by their link.
`timescale 1ns/1ps
module tb_top;
	import flash_cmd_pkg::*;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        erase_done = 1'b0;
	logic        prog_busy = 1'b0;
	logic        page_erase_start;
	logic        mass_erase_start;
	logic        info_area_map_enable;
	logic        prog_page_open;
	logic        prog_all_open;
	logic [6:0]  erase_page;
	logic [15:0] page_base_addr;
	logic [7:0]  sector_protect;
	logic [7:0]  command_byte;
	logic [7:0]  st;
	logic [31:0] q;
	logic        dbg_m = 1'b0;
	int          n_fail = 0;
	int          n_checks = 0;
	int          n_page = 0;
	int          n_mass = 0;

	flash_reg_if lnk ();
	flash_cmd_master flash_cmd_master_i (.ref_clk, .reset, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .bus(lnk));
	flash_cmd_ctl flash_cmd_ctl_i (.ref_clk, .reset, .bus(lnk), .erase_done, .prog_busy,
		.page_erase_start, .mass_erase_start, .erase_page, .page_base_addr,
		.info_area_map_enable, .prog_page_open, .prog_all_open, .sector_protect,
		.command_byte);
	flash_link_sva flash_link_sva_i (.ref_clk, .reset, .addr(lnk.addr), .wdata(lnk.wdata),
		.wr(lnk.wr), .rd(lnk.rd), .dbg(lnk.dbg), .rdata(lnk.rdata), .rvalid(lnk.rvalid));

	// Free-running 100 MHz clock.
	always #5 ref_clk = ~ref_clk;

	// Start pulses stand one cycle, so they are tallied at every edge.
	always @(posedge ref_clk) begin
		if (page_erase_start === 1'b1) n_page <= n_page + 1;
		if (mass_erase_start === 1'b1) n_mass <= n_mass + 1;
	end

	task automatic give_verdict();
		if (n_fail == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// One Avalon access; the request holds until waitrequest is sampled low.
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// The controller takes the link write at the edge where the host access ends,
	// so one more edge passes before any output is looked at.
	task automatic lw(input logic [11:0] a, input logic [7:0] d);
		av(1'b1, HOST_REQ, {10'h000, dbg_m, 1'b0, a, d}, q);
		@(posedge ref_clk);
	endtask

	// A link read is ordered, then the status word is polled until it is no longer busy.
	task automatic lr(input logic [11:0] a, output logic [7:0] d);
		av(1'b1, HOST_REQ, {10'h000, dbg_m, 1'b1, a, 8'h00}, q);
		do av(1'b0, HOST_STAT, 32'h0000_0000, q); while (q[0] !== 1'b0);
		d = q[15:8];
	endtask

	task automatic unlock();
		lw(ADDR_COMMAND, 8'h00);
		lw(ADDR_COMMAND, 8'h73);
		lw(ADDR_COMMAND, 8'h8c);
	endtask

	task automatic finish_erase();
		@(posedge ref_clk);
		erase_done <= 1'b1;
		@(posedge ref_clk);
		erase_done <= 1'b0;
	endtask

	task automatic t_reset_and_host();
		lr(ADDR_COMMAND, st);
		chk("status", st, 8'h00);
		lr(ADDR_PAGE, st);
		chk("page", st, 8'h00);
		chk("command", command_byte, 8'h00);
		av(1'b0, 4'h8, 32'h0000_0000, q);
		chk("unmapped", q[15:0], 16'h0000);
	endtask

	task automatic t_page_erase();
		lw(ADDR_COMMAND, 8'h00);
		lw(ADDR_COMMAND, 8'h73);
		lr(ADDR_COMMAND, st);
		chk("status", st, 8'h01);
		lw(ADDR_COMMAND, 8'h8c);
		lr(ADDR_COMMAND, st);
		chk("status", st, 8'h02);
		// Full-size part, so all seven page bits may be set.
		lw(ADDR_PAGE, 8'hff);
		lr(ADDR_COMMAND, st);
		chk("status", st, 8'h03);
		chk("info map", info_area_map_enable, 1'b1);
		chk("page base", page_base_addr, 16'hfe00);
		chk("windows", {prog_page_open, prog_all_open}, 2'b10);
		lw(ADDR_COMMAND, 8'h95);
		chk("command", command_byte, 8'h95);
		lr(ADDR_COMMAND, st);
		chk("busy code", st[5:3], 3'b010);
		chk("page starts", 16'(n_page), 16'd1);
		chk("erase page", erase_page, 7'h7f);
		finish_erase();
		lr(ADDR_COMMAND, st);
		chk("status", st, 8'h00);
	endtask

	task automatic t_bad_order();
		lw(ADDR_COMMAND, 8'h00);
		lw(ADDR_COMMAND, 8'h73);
		lw(ADDR_COMMAND, 8'h95);
		lr(ADDR_COMMAND, st);
		chk("status", st, 8'h00);
		chk("page starts", 16'(n_page), 16'd1);
		lw(ADDR_COMMAND, 8'h8c);
		lr(ADDR_COMMAND, st);
		chk("status", st, 8'h00);
		unlock();
		lw(ADDR_PAGE, 8'h7f);
		chk("info map", info_area_map_enable, 1'b0);
		lw(ADDR_COMMAND, 8'h63);
		lr(ADDR_COMMAND, st);
		chk("status", st, 8'h00);
		chk("mass starts", 16'(n_mass), 16'd0);
	endtask

	task automatic t_debug_path();
		dbg_m = 1'b1;
		unlock();
		lr(ADDR_COMMAND, st);
		chk("status", st, 8'h03);
		chk("all open", prog_all_open, 1'b1);
		lw(ADDR_COMMAND, 8'h63);
		lr(ADDR_COMMAND, st);
		chk("busy code", st[5:3], 3'b100);
		chk("mass starts", 16'(n_mass), 16'd1);
		finish_erase();
		lr(ADDR_COMMAND, st);
		chk("status", st, 8'h00);
		unlock();
		@(posedge ref_clk);
		prog_busy <= 1'b1;
		lr(ADDR_COMMAND, st);
		chk("busy code", st[5:3], 3'b001);
		@(posedge ref_clk);
		prog_busy <= 1'b0;
		lw(ADDR_COMMAND, 8'h00);
		lr(ADDR_COMMAND, st);
		chk("status", st, 8'h00);
		dbg_m = 1'b0;
	endtask

	task automatic t_protect();
		lw(ADDR_COMMAND, 8'h00);
		lw(ADDR_COMMAND, 8'h5e);
		lr(ADDR_COMMAND, st);
		chk("status", st, 8'h04);
		lw(ADDR_PAGE, 8'h03);
		lw(ADDR_PAGE, 8'h0c);
		lw(ADDR_PAGE, 8'h00);
		chk("protect", sector_protect, 8'h0f);
		lr(ADDR_PAGE, st);
		chk("protect read", st, 8'h0f);
		lw(ADDR_COMMAND, 8'h00);
		lr(ADDR_PAGE, st);
		chk("page", st, 8'h7f);
		lw(ADDR_PAGE, 8'h12);
		chk("protect", sector_protect, 8'h0f);
		lr(ADDR_PAGE, st);
		chk("page", st, 8'h12);
		// The debugger path may clear protect bits, unlike user code.
		dbg_m = 1'b1;
		lw(ADDR_COMMAND, 8'h00);
		lw(ADDR_COMMAND, 8'h5e);
		lw(ADDR_PAGE, 8'h01);
		chk("protect raw", sector_protect, 8'h01);
		lw(ADDR_COMMAND, 8'h00);
		dbg_m = 1'b0;
	endtask

	// Main sequence: hold reset for eight edges, then run every scenario.
	initial begin
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset_and_host();
		t_page_erase();
		t_bad_order();
		t_debug_path();
		t_protect();
		give_verdict();
	end

	// Watchdog well beyond the few hundred cycles the scenarios need.
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		give_verdict();
	end
endmodule // tb_top
